// *** src/asop_pkg.sv ***
/*
 * package for the sample output port: widths, latency, codes and states.
 * assumes a single 25 MHz clock domain and synchronous active-high reset.
 */
package asop_pkg;
    // ************************************************************
    // word and pipeline geometry
    // ************************************************************
    localparam int SAMPLE_WIDTH = 10;                 // bits per output word
    localparam int PIPE_LATENCY = 6;                  // sampling edge to output, cycles
    // ************************************************************
    // code limits and coding
    // ************************************************************
    localparam logic [9:0] CODE_MIN = 10'h000;        // under-range clamp code
    localparam logic [9:0] CODE_MAX = 10'h3FF;        // over-range clamp code
    localparam logic [9:0] MSB_FLIP = 10'h200;        // offset binary to two's complement
    localparam logic [9:0] WORD_RESET = 10'h000;      // output word after reset
    // ************************************************************
    // clock figures
    // ************************************************************
    localparam int CLK_MIN_MHZ = 10;                  // slowest conversion clock
    localparam int CLK_MAX_MHZ = 65;                  // fastest conversion clock
    localparam int CLK_RATE_MHZ = 25;                 // rate this design is built for
    // ************************************************************
    // operating states
    // ************************************************************
    typedef enum logic [1:0] {
        ASOP_STANDBY,
        ASOP_FILLING,
        ASOP_RUNNING
    } asop_mode_t;
endpackage

// *** src/asop_stage_if.sv ***
/*
 * interface carrying raw samples into the delay line and words out of it.
 * assumes both ends share the top-level clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface asop_stage_if;
    logic [9:0] raw_in;        // clamped sample entering the line
    logic shift_en;            // advance the line this cycle
    logic [9:0] raw_out;       // sample leaving the line
    modport feeder (output raw_in, output shift_en, input raw_out);
    modport line (input raw_in, input shift_en, output raw_out);
endinterface
`default_nettype wire

// *** src/asop_delay_line.sv ***
/*
 * fixed-length delay line holding samples in flight through the pipeline.
 * assumes the feeder advances it once per converting clock.
 */
`timescale 1ns/1ns
`default_nettype none
module asop_delay_line #(
    parameter int DEPTH = 5
) (
    input wire logic clock,
    input wire logic rst,
    asop_stage_if.line stg
);
    import asop_pkg::*;
    // ************************************************************
    // storage
    // ************************************************************
    logic [9:0] stage_reg [DEPTH];      // one slot per pipeline stage
    logic [9:0] stage_next [DEPTH];     // next contents
    // next-value logic, one slot per generate entry
    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
        logic [9:0] prev_word;          // what this slot takes when the line advances
        // head slot is fed from outside, so no slot below zero is ever indexed
        if (i == 0) begin : g_head
            assign prev_word = stg.raw_in;
        end else begin : g_body
            assign prev_word = stage_reg[i-1];
        end
        always_comb begin
            if (stg.shift_en) begin
                stage_next[i] = prev_word;
            end else begin
                stage_next[i] = stage_reg[i];
            end
        end
        // register the slot
        always_ff @(posedge clock) begin
            if (rst) begin
                stage_reg[i] <= WORD_RESET;
            end else begin
                stage_reg[i] <= stage_next[i];
            end
        end
    end
    assign stg.raw_out = stage_reg[DEPTH-1];
endmodule
`default_nettype wire

// *** src/asop_top.sv ***
/*
 * digital side of a 10-bit pipelined converter: samples, delays, codes, holds.
 * assumes clock is the conversion clock and all inputs are synchronous to it.
 */
// Overview of operation
// - one sample per converting rising edge, 10-bit word
// - word appears six cycles after its sample
// - format high two's complement, low offset binary
// - standby while hold high, converting while low
// - one output word every converting clock cycle
// - bit 0 least, bit 9 most significant
// - clamp under-range to 0, over-range to 1023
`timescale 1ns/1ns
`default_nettype none
module asop_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [10:0] analog_code,
    input wire logic data_format_select,
    input wire logic low_power_hold,
    output logic [asop_pkg::SAMPLE_WIDTH-1:0] sample_word_bits,
    output logic sample_valid,
    output logic converting
);
    import asop_pkg::*;
    // ************************************************************
    // input stage
    // ************************************************************
    // analog_code is a signed quantiser value; range -512..1535 covers both clamp sides
    logic [9:0] clamped;             // quantised value limited to code range
    logic [9:0] sample_reg;          // stage 1: sampled word
    logic [9:0] sample_next;
    asop_mode_t mode_reg;            // operating state
    asop_mode_t mode_next;
    logic [2:0] fill_reg;            // words accepted since fill began
    logic [2:0] fill_next;
    logic [9:0] word_reg;            // output flip-flops
    logic [9:0] word_next;
    logic [9:0] coded;               // line output in chosen coding
    asop_stage_if stg ();            // link to delay line
    // clamp: 11'h600..11'h7FF are negative (under range), 11'h400..11'h5FF exceed 1023
    always_comb begin
        if (analog_code[10] && analog_code[9]) begin
            clamped = CODE_MIN;
        end else if (analog_code[10]) begin
            clamped = CODE_MAX;
        end else begin
            clamped = analog_code[9:0];
        end
    end
    // ************************************************************
    // mode control
    // ************************************************************
    // standby freezes the pipe; leaving it refills for six cycles
    always_comb begin
        mode_next = mode_reg;
        fill_next = fill_reg;
        if (low_power_hold) begin
            mode_next = ASOP_STANDBY;
            fill_next = 3'h0;
        end else begin
            unique case (mode_reg)
                ASOP_STANDBY: begin
                    mode_next = ASOP_FILLING;
                    fill_next = 3'h1;
                end
                ASOP_FILLING: begin
                    if (fill_reg == 3'(PIPE_LATENCY - 1)) begin
                        mode_next = ASOP_RUNNING;
                    end else begin
                        fill_next = fill_reg + 3'h1;
                    end
                end
                ASOP_RUNNING: begin
                    mode_next = ASOP_RUNNING;
                end
            endcase
        end
    end
    // register mode state
    always_ff @(posedge clock) begin
        if (rst) begin
            mode_reg <= ASOP_STANDBY;
            fill_reg <= 3'h0;
        end else begin
            mode_reg <= mode_next;
            fill_reg <= fill_next;
        end
    end
    // ************************************************************
    // datapath
    // ************************************************************
    assign converting = !low_power_hold;
    assign stg.raw_in = sample_reg;
    assign stg.shift_en = converting;
    // sample every converting edge, hold in standby
    always_comb begin
        sample_next = converting ? clamped : sample_reg;
    end
    // coding selected at the output
    always_comb begin
        if (data_format_select) begin
            coded = stg.raw_out ^ MSB_FLIP;
        end else begin
            coded = stg.raw_out;
        end
    end
    // output stage: sample + 4 line slots + output = 6 edges
    always_comb begin
        word_next = converting ? coded : word_reg;
    end
    // register datapath
    always_ff @(posedge clock) begin
        if (rst) begin
            sample_reg <= WORD_RESET;
            word_reg <= WORD_RESET;
        end else begin
            sample_reg <= sample_next;
            word_reg <= word_next;
        end
    end
    asop_delay_line #(.DEPTH(PIPE_LATENCY - 2)) u_line (
        .clock(clock),
        .rst(rst),
        .stg(stg)
    );
    // bit 0 is the least significant pin
    assign sample_word_bits = word_reg;
    // pipeline full: words now reflect real samples
    assign sample_valid = (mode_reg == ASOP_RUNNING) && converting;
    // ************************************************************
    // assertions
    // ************************************************************
    logic conv_d;      // helper: converting in previous cycle
    always_ff @(posedge clock) begin
        conv_d <= rst ? 1'b0 : converting;
    end
    AST_LATENCY: assert property (@(posedge clock) disable iff (rst)
        (converting && !data_format_select) [*7] |->
            sample_word_bits == $past(clamped, 6))
        else $error("word does not match sample six cycles earlier");
    AST_TWOS: assert property (@(posedge clock) disable iff (rst)
        (converting && data_format_select) [*7] |->
            sample_word_bits == ($past(clamped, 6) ^ MSB_FLIP))
        else $error("two's complement coding wrong");
    AST_UNDER: assert property (@(posedge clock) disable iff (rst)
        (analog_code[10] && analog_code[9]) |-> clamped == CODE_MIN)
        else $error("under-range not clamped to zero");
    AST_OVER: assert property (@(posedge clock) disable iff (rst)
        (analog_code[10] && !analog_code[9]) |-> clamped == CODE_MAX)
        else $error("over-range not clamped to full code");
    AST_HOLD: assert property (@(posedge clock) disable iff (rst)
        low_power_hold |=> $stable(sample_word_bits) && !sample_valid)
        else $error("output moved in standby");
    AST_SAMPLE: assert property (@(posedge clock) disable iff (rst)
        converting |=> sample_reg == $past(clamped))
        else $error("sample not taken on edge");
    AST_RATE: assert property (@(posedge clock) disable iff (rst)
        sample_valid [*2] |-> conv_d)
        else $error("word stream broken while valid");
    AST_FILL: assert property (@(posedge clock) disable iff (rst)
        $fell(low_power_hold) ##1 (!low_power_hold) [*6] |->
            sample_valid && !$past(sample_valid))
        else $error("valid not after six words");
    COV_RUN: cover property (@(posedge clock) disable iff (rst) $rose(sample_valid));
    COV_SB: cover property (@(posedge clock) disable iff (rst) $rose(low_power_hold));
    COV_TC: cover property (@(posedge clock) disable iff (rst) sample_valid && data_format_select);
    COV_CLAMP: cover property (@(posedge clock) disable iff (rst) analog_code[10] && converting);
endmodule
`default_nettype wire

// *** testbench/asop_rx_model.sv ***
/* receiver model: registers every converter word on the conversion clock.
   assumes the converter outputs change just after rising edges. */
`timescale 1ns/1ns
`default_nettype none
module asop_rx_model (
    input wire logic clock,
    input wire logic [asop_pkg::SAMPLE_WIDTH-1:0] word,
    input wire logic valid,
    output logic [asop_pkg::SAMPLE_WIDTH-1:0] cap_word,
    output logic cap_strobe
);
    import asop_pkg::*;
    // same clock as the converter, fill words dropped via valid
    always_ff @(posedge clock) begin
        cap_word <= word;
        cap_strobe <= valid;
    end
endmodule
`default_nettype wire

// *** testbench/asop_top_tb.sv ***
/* self-checking bench for the sample output port.
   assumes the receiver model and the package are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module asop_top_tb;
    import asop_pkg::*;
    logic clock, rst, fmt, hold, valid, conv, cap_strobe, fmt_prev, hold_prev, rst_prev;
    logic [10:0] code;
    logic [9:0] word, cap_word, last_word, e;
    logic [9:0] hist [6];
    logic [9:0] exp_q [$];
    logic [10:0] edge_codes [8] = '{11'h400, 11'h7FF, 11'h000, 11'h001, 11'h1FF, 11'h200, 11'h3FE, 11'h3FF};
    int run, n_mismatch, checked, seed;
    // ************************************************************
    // design, receiver and clock
    // ************************************************************
    asop_top u_dut (.clock(clock), .rst(rst), .analog_code(code), .data_format_select(fmt),
        .low_power_hold(hold), .sample_word_bits(word), .sample_valid(valid), .converting(conv));
    asop_rx_model u_rx (.clock(clock), .word(word), .valid(valid), .cap_word(cap_word), .cap_strobe(cap_strobe));
    // 25 MHz, inside the allowed clock range
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // ************************************************************
    // comparison and closing
    // ************************************************************
    task automatic check(input logic [9:0] seen, input logic [9:0] want, input string what);
        checked++;
        if (seen !== want) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // mode 0 offset, 1 two's complement, 2 random format, 3 plus standby bursts
    task automatic run_cycles(input int n, input int mode);
        repeat (n) begin
            @(negedge clock);
            code = 11'($random(seed));
            fmt = (mode < 2) ? mode[0] : 1'($random(seed));
            hold = (mode == 3) ? ((32'($random(seed)) & 32'h3) == 32'h0) : 1'b0;
        end
    endtask
    task automatic do_reset();
        @(negedge clock);
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
    endtask
    // ************************************************************
    // expected words: queued for every sample that should come out valid
    // ************************************************************
    always @(posedge clock) begin
        // the word on the pins at a reset edge is still captured as valid
        if (!hold && run >= PIPE_LATENCY) exp_q.push_back(fmt_prev ? (hist[5] ^ MSB_FLIP) : hist[5]);
        if (rst || hold) begin
            run = 0;
        end else begin
            for (int i = 5; i > 0; i--) hist[i] = hist[i-1];
            hist[0] = (code[10] && code[9]) ? CODE_MIN : (code[10] ? CODE_MAX : code[9:0]);
            fmt_prev = fmt;
            run++;
        end
    end
    // ************************************************************
    // output watcher: standby, reset and captured words
    // ************************************************************
    always @(posedge clock) begin
        if (rst_prev) check(word, WORD_RESET, "reset word");
        if (!rst) begin
            check({9'h000, conv}, {9'h000, ~hold}, "converting");
            if (hold) check({9'h000, valid}, 10'h000, "valid in standby");
            if (hold && hold_prev) check(word, last_word, "frozen word");
        end
        // captures keep flowing through a reset edge, so they are compared there too
        if (cap_strobe) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : ~cap_word;
            check(cap_word, e, "word");
        end
        hold_prev = hold && !rst;
        rst_prev = rst;
        last_word = word;
    end
    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        seed = 32'hE4F6;
        rst = 1'b1;
        hold = 1'b0;
        fmt = 1'b0;
        code = 11'h000;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        run_cycles(40, 0);
        $display("test offset binary stream done");
        run_cycles(40, 1);
        $display("test two's complement stream done");
        run_cycles(60, 2);
        $display("test format change in flight done");
        foreach (edge_codes[i]) begin
            @(negedge clock);
            code = edge_codes[i];
        end
        run_cycles(10, 2);
        $display("test clamp and boundary codes done");
        run_cycles(200, 3);
        $display("test standby bursts done");
        do_reset();
        run_cycles(40, 2);
        $display("test mid-run reset done");
        hold = 1'b1;
        repeat (4) @(negedge clock);
        check(10'(exp_q.size()), 10'h000, "words left over");
        close_out();
    end
    initial begin
        #(40 * 2000);
        n_mismatch++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        close_out();
    end
endmodule
`default_nettype wire
